// ==== rtl/dsb_pkg.sv ====
/*
  dsb_pkg: shared constants for the dual image flash swap boot block.
  Assumes a 100 MHz controller clock and 32-bit AXI4-Lite register access.
*/
package dsb_pkg;
  // clock and flash timing guidance
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned FLASH_CLK_MHZ    = 16;
  localparam int unsigned WRITE_TYP_US     = 46;
  localparam int unsigned FAST_WRITE_US    = 20;
  localparam int unsigned SIGN_TYP_US      = 8192;   // 8.192 ms
  localparam int unsigned SIGN_FLASH_CYC   = 131072; // 128k flash clock cycles
  localparam int unsigned WRITE_TYP_CYC    = WRITE_TYP_US * CLK_MHZ;
  localparam int unsigned FAST_WRITE_CYC   = FAST_WRITE_US * CLK_MHZ;
  localparam int unsigned SIGN_TYP_CYC     = SIGN_TYP_US * CLK_MHZ;
  localparam int unsigned OPCNT_W          = 24;

  // address map of the two 512 kB blocks
  localparam int unsigned FADDR_W          = 20;
  localparam logic [19:0] BLK0_TOP         = 20'h7ffff;
  localparam logic [19:0] BLK1_BASE        = 20'h80000;
  localparam int unsigned BLK_SEL_BIT      = 19;
  localparam logic [19:0] UKEY_BLK0_ADDR   = 20'h7ffc0;
  localparam logic [19:0] UKEY_BLK1_ADDR   = 20'hfffc0;
  localparam logic [19:0] TKEY_OFFSET      = 20'h00008;
  localparam logic [31:0] KEY_ERASED       = 32'hffffffff;
  localparam logic [31:0] KEY_PASSED       = 32'h00000000;

  // register map (byte addresses within the block)
  localparam int unsigned RADDR_W          = 8;
  localparam logic [7:0]  REG_USER_SETUP   = 8'h00;
  localparam logic [7:0]  REG_BOOT_STATUS  = 8'h04;
  localparam logic [7:0]  REG_UKEY0        = 8'h08;
  localparam logic [7:0]  REG_UKEY1        = 8'h0c;
  localparam logic [7:0]  REG_TKEY0        = 8'h10;
  localparam logic [7:0]  REG_TKEY1        = 8'h14;
  localparam logic [7:0]  REG_OP_TIME      = 8'h18;
  localparam logic [31:0] USER_SETUP_RST   = 32'h00000011;
  localparam logic [31:0] USER_SETUP_WMASK = 32'h0000001f;
  localparam int unsigned SWAP_BIT         = 3;
  localparam logic [1:0]  RESP_OKAY        = 2'b00;
  localparam logic [1:0]  RESP_SLVERR      = 2'b10;

  // boot status fields
  localparam int unsigned ST_MODE_LSB      = 0;
  localparam int unsigned ST_DONE_BIT      = 4;
  localparam int unsigned ST_SWAP_BIT      = 5;
  localparam int unsigned ST_SLOW_BIT      = 6;

  typedef enum logic [2:0] {
    MODE_DEBUG    = 3'h0,
    MODE_DOWNLOAD = 3'h1,
    MODE_NORMAL_A = 3'h2,
    MODE_TRIAL_A  = 3'h3,
    MODE_NORMAL_B = 3'h4,
    MODE_TRIAL_B  = 3'h5
  } dsb_mode_e;

  typedef enum logic [2:0] {
    SEL_START  = 3'b000,
    SEL_RD_U0  = 3'b001,
    SEL_RD_U1  = 3'b011,
    SEL_RD_T0  = 3'b010,
    SEL_RD_T1  = 3'b110,
    SEL_DECIDE = 3'b111,
    SEL_DONE   = 3'b101
  } dsb_sel_e;
endpackage

// ==== rtl/dsb_swap_boot.sv ====
/*
  dsb_swap_boot: image selection after reset, address swap, fetch stall
  and register access for a dual 512 kB flash program store.
  Assumes flash arrays answer key reads on a simple request/valid port,
  report per-block long-operation busy, and software uses AXI4-Lite.
*/
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
// Contract
// [RULE1] unswapped: 0..0x7FFFF go to block zero, 0x80000..0xFFFFF to block one
// [RULE2] swapped: low half goes to block one, upper half to block zero
// [RULE3] swap bit 3 of user setup register selects the address map
// [RULE4] update keys at 0x7FFC0/0xFFFC0, trial keys eight bytes above
// [RULE5] every reset reruns selection; mode changes only through reset
// [RULE6] boot select pin high skips key checks, enters debug mode
// [RULE7] larger update key gives candidate, active if its trial key is zero
// [RULE8] else the other image is active if its trial key is zero
// [RULE9] neither trial key zero: no user image, downloader mode
// [RULE10] erased update key counts as minus one in comparison
// [RULE11] erased trial key means untested download; zero means trial passed
// [RULE12] user code runs trial when active update key is the smaller
// [RULE13] download writes update key plus one, trial key erased, then reset
// [RULE14] verified new image gets trial key zero, then continue or reset
// [RULE15] reset mid-trial restarts the trial from the old image
// [RULE16] fetches from a block stall while a long operation runs there
// [RULE17] software detects completion by status flags, not typical times
// [RULE18] never program one address twice between erases
// [RULE19] never drive a bit to zero twice between erases
// [RULE20] a write takes about 46 us, fast page writes about 20 us
// [RULE21] signing a full 512 kB space takes about 128k flash cycles
// [RULE22] image CRC at top word is optional, selection ignores it
// [RULE23] software clears instruction cache after toggling swap
// [RULE24] swap comes out of reset unswapped; set by selection or software
`timescale 1ns/1ps
`default_nettype none
module dsb_swap_boot
  import dsb_pkg::*;
#(
  parameter int unsigned SLOW_OP_CYC = SIGN_TYP_CYC  // busy longer than this is flagged
) (
  input  wire logic                aclk,                 // 100 MHz clock
  input  wire logic                aresetn,              // synchronous reset, active low
  input  wire logic [RADDR_W-1:0]  s_axil_awaddr,        // write address
  input  wire logic                s_axil_awvalid,       // write address valid
  output logic                     s_axil_awready,       // write address ready
  input  wire logic [31:0]         s_axil_wdata,         // write data
  input  wire logic [3:0]          s_axil_wstrb,         // write byte strobes
  input  wire logic                s_axil_wvalid,        // write data valid
  output logic                     s_axil_wready,        // write data ready
  output logic [1:0]               s_axil_bresp,         // write response
  output logic                     s_axil_bvalid,        // write response valid
  input  wire logic                s_axil_bready,        // write response ready
  input  wire logic [RADDR_W-1:0]  s_axil_araddr,        // read address
  input  wire logic                s_axil_arvalid,       // read address valid
  output logic                     s_axil_arready,       // read address ready
  output logic [31:0]              s_axil_rdata,         // read data
  output logic [1:0]               s_axil_rresp,         // read response
  output logic                     s_axil_rvalid,        // read data valid
  input  wire logic                s_axil_rready,        // read data ready
  input  wire logic                boot_select_pin,      // high: debug boot
  input  wire logic                serial_wire_boot_pin, // serial download strap
  output logic                     key_rd_req,           // key read request
  output logic [FADDR_W-1:0]       key_rd_addr,          // physical key address
  input  wire logic                key_rd_valid,         // key read data valid
  input  wire logic [31:0]         key_rd_data,          // key read data
  input  wire logic                fetch_valid,          // cpu fetch request
  input  wire logic [FADDR_W-1:0]  fetch_addr,           // cpu fetch address
  output logic                     fetch_block,          // selected flash block
  output logic [BLK_SEL_BIT-1:0]   fetch_offset,         // offset within block
  output logic                     fetch_stall,          // hold the fetch
  input  wire logic [1:0]          flash_busy,           // long operation per block
  output logic [2:0]               boot_mode,            // selected mode
  output logic                     boot_done,            // selection finished
  output logic                     swap_active           // address map swapped
);

  // physical block for a logical address under the current map
  function automatic logic phys_block(input logic [FADDR_W-1:0] a, input logic swp);
    phys_block = a[BLK_SEL_BIT] ^ swp; // RULE1 RULE2
  endfunction

  // signed compare makes an erased key read as minus one
  function automatic logic key_greater(input logic [31:0] a, input logic [31:0] b);
    key_greater = $signed(a) > $signed(b); // RULE10
  endfunction

  dsb_sel_e            sel_q;
  dsb_mode_e           mode_q;
  logic [31:0]         ukey0_q, ukey1_q, tkey0_q, tkey1_q;
  logic [31:0]         setup_q;
  logic                serial_q;
  logic                req_q;
  logic [FADDR_W-1:0]  addr_q;
  logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         rdata_q;
  logic                fblk_q, fstall_q;
  logic [BLK_SEL_BIT-1:0] foff_q;
  logic [OPCNT_W-1:0]  opcnt_q, optime_q;
  logic                slow_q, done_q;
  logic                wr_fire, rd_fire, wr_setup;
  logic [31:0]         wmask;
  logic                cand_q_d;
  logic [31:0]         status_w;

  assign wr_fire  = awready_q & s_axil_awvalid & wready_q & s_axil_wvalid;
  assign rd_fire  = arready_q & s_axil_arvalid;
  assign wr_setup = wr_fire & (s_axil_awaddr == REG_USER_SETUP);
  assign wmask    = {{8{s_axil_wstrb[3]}}, {8{s_axil_wstrb[2]}},
                     {8{s_axil_wstrb[1]}}, {8{s_axil_wstrb[0]}}} & USER_SETUP_WMASK;
  assign cand_q_d = key_greater(ukey1_q, ukey0_q); // RULE7
  assign status_w = {25'h0, slow_q, setup_q[SWAP_BIT], done_q, serial_q, mode_q};

  // selection sequencer: straps first, then four key reads, then decide
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_q  <= SEL_START; // RULE5
      done_q <= 1'b0;
    end else begin
      done_q <= (sel_q == SEL_START && boot_select_pin) || (sel_q inside {SEL_DECIDE, SEL_DONE});
      unique case (sel_q)
        SEL_START:  sel_q <= boot_select_pin ? SEL_DONE : SEL_RD_U0; // RULE6
        SEL_RD_U0:  if (key_rd_valid && req_q) sel_q <= SEL_RD_U1;
        SEL_RD_U1:  if (key_rd_valid && req_q) sel_q <= SEL_RD_T0;
        SEL_RD_T0:  if (key_rd_valid && req_q) sel_q <= SEL_RD_T1;
        SEL_RD_T1:  if (key_rd_valid && req_q) sel_q <= SEL_DECIDE;
        SEL_DECIDE: sel_q <= SEL_DONE;
        SEL_DONE:   sel_q <= SEL_DONE;
      endcase
    end
  end

  // straps are caught by the clock after reset release, never by the reset itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_q <= 1'b0;
    end else if (sel_q == SEL_START) begin
      serial_q <= serial_wire_boot_pin;
    end
  end

  // key read port: request stands until valid, drops one cycle between reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q  <= 1'b0;
      addr_q <= '0;
    end else begin
      unique case (sel_q)
        SEL_RD_U0: addr_q <= UKEY_BLK0_ADDR;                // RULE4
        SEL_RD_U1: addr_q <= UKEY_BLK1_ADDR;                // RULE4
        SEL_RD_T0: addr_q <= UKEY_BLK0_ADDR + TKEY_OFFSET;  // RULE4
        SEL_RD_T1: addr_q <= UKEY_BLK1_ADDR + TKEY_OFFSET;  // RULE4
        default:   addr_q <= addr_q;
      endcase
      if (req_q && key_rd_valid) begin
        req_q <= 1'b0;
      end else begin
        req_q <= (sel_q == SEL_RD_U0) || (sel_q == SEL_RD_U1) ||
                 (sel_q == SEL_RD_T0) || (sel_q == SEL_RD_T1);
      end
    end
  end

  // key capture; the image crc is never read, selection does not need it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ukey0_q <= KEY_ERASED;
      ukey1_q <= KEY_ERASED;
      tkey0_q <= KEY_ERASED;
      tkey1_q <= KEY_ERASED;
    end else if (req_q && key_rd_valid) begin
      unique case (sel_q)
        SEL_RD_U0: ukey0_q <= key_rd_data;
        SEL_RD_U1: ukey1_q <= key_rd_data;
        SEL_RD_T0: tkey0_q <= key_rd_data; // RULE11
        SEL_RD_T1: tkey1_q <= key_rd_data; // RULE11
        default:   ukey0_q <= ukey0_q;
      endcase
    end
  end

  // mode decision, fixed until the next reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_DOWNLOAD; // RULE5
    end else if (sel_q == SEL_START && boot_select_pin) begin
      mode_q <= MODE_DEBUG; // RULE6
    end else if (sel_q == SEL_DECIDE) begin
      if (!cand_q_d && tkey0_q == KEY_PASSED) begin
        mode_q <= key_greater(ukey0_q, ukey1_q) ? MODE_NORMAL_A : MODE_TRIAL_A; // RULE7
      end else if (cand_q_d && tkey1_q == KEY_PASSED) begin
        mode_q <= key_greater(ukey1_q, ukey0_q) ? MODE_NORMAL_B : MODE_TRIAL_B; // RULE7
      end else if (!cand_q_d && tkey1_q == KEY_PASSED) begin
        // candidate untested: fall back to the old image, which then runs the trial
        mode_q <= key_greater(ukey1_q, ukey0_q) ? MODE_NORMAL_B : MODE_TRIAL_B; // RULE8 RULE15
      end else if (cand_q_d && tkey0_q == KEY_PASSED) begin
        mode_q <= key_greater(ukey0_q, ukey1_q) ? MODE_NORMAL_A : MODE_TRIAL_A; // RULE8 RULE15
      end else begin
        mode_q <= MODE_DOWNLOAD; // RULE9
      end
    end
  end

  // user setup register; selection owns the swap bit in its decide cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_q <= USER_SETUP_RST; // RULE24
    end else if (sel_q == SEL_DECIDE) begin
      setup_q[SWAP_BIT] <= (!cand_q_d && tkey0_q != KEY_PASSED && tkey1_q == KEY_PASSED) ||
                           (cand_q_d && tkey1_q == KEY_PASSED); // RULE24 RULE8
    end else if (wr_setup) begin
      setup_q <= (setup_q & ~wmask) | (s_axil_wdata & wmask); // RULE3 RULE24
    end
  end

  // fetch decode and stall, one cycle behind the request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fblk_q   <= 1'b0;
      foff_q   <= '0;
      fstall_q <= 1'b0;
    end else begin
      fblk_q   <= phys_block(fetch_addr, setup_q[SWAP_BIT]); // RULE1 RULE2 RULE3
      foff_q   <= fetch_addr[BLK_SEL_BIT-1:0];
      // also hold fetches until selection has fixed the map
      fstall_q <= fetch_valid && (!done_q ||
                  flash_busy[phys_block(fetch_addr, setup_q[SWAP_BIT])]); // RULE16
    end
  end

  // operation timer: last busy duration and a flag past the signing estimate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opcnt_q  <= '0;
      optime_q <= '0;
      slow_q   <= 1'b0;
    end else begin
      if (|flash_busy) begin
        if (opcnt_q != {OPCNT_W{1'b1}}) opcnt_q <= opcnt_q + 1'b1; // RULE20 RULE21
        if (opcnt_q == OPCNT_W'(SLOW_OP_CYC)) slow_q <= 1'b1; // RULE21
      end else if (opcnt_q != '0) begin
        optime_q <= opcnt_q;
        opcnt_q  <= '0;
      end
      // a new overrun in the same cycle as the clear wins
      if (wr_fire && s_axil_awaddr == REG_OP_TIME && s_axil_wstrb[0] &&
          !(|flash_busy && opcnt_q == OPCNT_W'(SLOW_OP_CYC))) begin
        slow_q <= 1'b0;
      end
    end
  end

  // write channel: address and data taken together, response next cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else begin
      awready_q <= s_axil_awvalid && s_axil_wvalid && !awready_q && !bvalid_q;
      wready_q  <= s_axil_awvalid && s_axil_wvalid && !awready_q && !bvalid_q;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (s_axil_awaddr == REG_USER_SETUP || s_axil_awaddr == REG_OP_TIME) ?
                    RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axil_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: one cycle from address taken to data valid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= RESP_OKAY;
    end else begin
      arready_q <= s_axil_arvalid && !arready_q && !rvalid_q;
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rresp_q  <= RESP_OKAY;
        unique case (s_axil_araddr)
          REG_USER_SETUP:  rdata_q <= setup_q;
          REG_BOOT_STATUS: rdata_q <= status_w;
          REG_UKEY0:       rdata_q <= ukey0_q;
          REG_UKEY1:       rdata_q <= ukey1_q;
          REG_TKEY0:       rdata_q <= tkey0_q;
          REG_TKEY1:       rdata_q <= tkey1_q;
          REG_OP_TIME:     rdata_q <= {8'h00, optime_q};
          default: begin
            rdata_q <= '0;
            rresp_q <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid_q && s_axil_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  assign s_axil_awready = awready_q;
  assign s_axil_wready  = wready_q;
  assign s_axil_bvalid  = bvalid_q;
  assign s_axil_bresp   = bresp_q;
  assign s_axil_arready = arready_q;
  assign s_axil_rvalid  = rvalid_q;
  assign s_axil_rdata   = rdata_q;
  assign s_axil_rresp   = rresp_q;
  assign key_rd_req     = req_q;
  assign key_rd_addr    = addr_q;
  assign fetch_block    = fblk_q;
  assign fetch_offset   = foff_q;
  assign fetch_stall    = fstall_q;
  assign boot_mode      = mode_q;
  assign boot_done      = done_q;
  assign swap_active    = setup_q[SWAP_BIT];

endmodule // dsb_swap_boot
`default_nettype wire

// ==== verification/dsb_flash_model.sv ====
/*
  dsb_flash_model: key words of the two flash blocks, answering key reads.
  Assumes the bench sets keys and answer delay before each reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dsb_flash_model import dsb_pkg::*; (
  input  wire logic               aclk,         // controller clock
  input  wire logic               key_rd_req,   // read request level
  input  wire logic [FADDR_W-1:0] key_rd_addr,  // physical key address
  output logic                    key_rd_valid, // one-cycle answer
  output logic [31:0]             key_rd_data,  // key value
  input  wire logic [31:0]        ukey0,        // update key, block zero
  input  wire logic [31:0]        ukey1,        // update key, block one
  input  wire logic [31:0]        tkey0,        // trial key, block zero
  input  wire logic [31:0]        tkey1,        // trial key, block one
  input  wire logic [3:0]         lat           // answer delay in cycles
);
  logic [3:0]  wait_q;
  logic [31:0] word;
  // stored key words; erased keys are passed on as all ones
  always_comb begin
    case (key_rd_addr)
      UKEY_BLK0_ADDR:               word = ukey0;
      UKEY_BLK1_ADDR:               word = ukey1;
      UKEY_BLK0_ADDR + TKEY_OFFSET: word = tkey0;
      UKEY_BLK1_ADDR + TKEY_OFFSET: word = tkey1;
      default:                      word = 32'h5a5a5a5a;
    endcase
  end
  initial begin
    key_rd_valid = 1'b0;
    key_rd_data  = 32'h0;
    wait_q       = 4'h0;
  end
  // data toggles outside the answer cycle so a late sample never sees a key
  always @(posedge aclk) begin
    key_rd_valid <= 1'b0;
    key_rd_data  <= ~key_rd_data;
    if (!key_rd_req || key_rd_valid) begin
      wait_q <= 4'h0;
    end else if (wait_q < lat) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      key_rd_valid <= 1'b1;
      key_rd_data  <= word;
    end
  end
endmodule // dsb_flash_model
`default_nettype wire

// ==== verification/dsb_swap_boot_chk.sv ====
/*
  dsb_swap_boot_chk: port assertions for map decode, fetch stall, key walk,
  boot mode and swap state. Assumes one clock and the sync low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dsb_swap_boot_chk import dsb_pkg::*; (
  input wire logic                   aclk,            // clock
  input wire logic                   aresetn,         // reset, active low
  input wire logic                   boot_select_pin, // debug strap
  input wire logic                   key_rd_req,      // key request
  input wire logic [FADDR_W-1:0]     key_rd_addr,     // key address
  input wire logic                   key_rd_valid,    // key answer
  input wire logic                   fetch_valid,     // fetch request
  input wire logic [FADDR_W-1:0]     fetch_addr,      // logical address
  input wire logic                   fetch_block,     // decoded block
  input wire logic [BLK_SEL_BIT-1:0] fetch_offset,    // block offset
  input wire logic                   fetch_stall,     // fetch hold
  input wire logic [1:0]             flash_busy,      // busy per block
  input wire logic [2:0]             boot_mode,       // selected mode
  input wire logic                   boot_done,       // selection over
  input wire logic                   swap_active      // map swapped
);
  logic busy_here;
  // busy of the physical block this fetch lands in
  assign busy_here = flash_busy[fetch_addr[BLK_SEL_BIT] ^ swap_active];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // boot steps after release, and one key taken then the next asked for
  sequence rel_s; $rose(aresetn); endsequence
  sequence dbg_s; ##2 boot_done && boot_mode == MODE_DEBUG; endsequence
  sequence walk_s; ##2 key_rd_req && key_rd_addr == UKEY_BLK0_ADDR; endsequence
  sequence taken_s(logic [19:0] a); key_rd_req && key_rd_valid && key_rd_addr == a; endsequence
  map_plain_a:
    assert property ($past(aresetn) && !$past(swap_active) |-> fetch_block ==
      $past(fetch_addr[BLK_SEL_BIT]) && fetch_offset == $past(fetch_addr[18:0]))
    else $error("unswapped fetch decode wrong");
  map_swap_a:
    assert property ($past(aresetn) && $past(swap_active) |->
      fetch_block != $past(fetch_addr[BLK_SEL_BIT])) else $error("swapped fetch decode wrong");
  stall_busy_a:
    assert property ($past(aresetn) |-> fetch_stall ==
      ($past(fetch_valid) && (!$past(boot_done) || $past(busy_here))))
    else $error("fetch stall wrong");
  debug_boot_a:
    assert property (rel_s ##0 boot_select_pin |-> dbg_s) else $error("debug boot missed");
  key_walk_a:
    assert property (rel_s ##0 !boot_select_pin |-> walk_s) else $error("key walk not begun");
  key_next_a:
    assert property (taken_s(UKEY_BLK0_ADDR) |=> !key_rd_req ##1
      key_rd_req && key_rd_addr == UKEY_BLK1_ADDR) else $error("second key address wrong");
  key_trial_a:
    assert property (taken_s(UKEY_BLK1_ADDR) |=> !key_rd_req ##1
      key_rd_req && key_rd_addr == UKEY_BLK0_ADDR + TKEY_OFFSET) else $error("trial key wrong");
  key_hold_a:
    assert property (key_rd_req && !key_rd_valid |=> key_rd_req && $stable(key_rd_addr))
    else $error("key request dropped early");
  mode_hold_a:
    assert property ($past(aresetn) && $past(boot_done) |-> boot_done && $stable(boot_mode))
    else $error("mode changed without reset");
  swap_rst_a:
    assert property (rel_s |-> !swap_active) else $error("swap set out of reset");
endmodule // dsb_swap_boot_chk
bind dsb_swap_boot dsb_swap_boot_chk i_chk (
  .aclk, .aresetn, .boot_select_pin, .key_rd_req, .key_rd_addr, .key_rd_valid,
  .fetch_valid, .fetch_addr, .fetch_block, .fetch_offset, .fetch_stall,
  .flash_busy, .boot_mode, .boot_done, .swap_active);
`default_nettype wire

// ==== verification/dsb_swap_boot_tb.sv ====
/*
  dsb_swap_boot_tb: boots the block over a table of key sets, then checks
  map, fetch stall and registers. Assumes the key model and bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module dsb_swap_boot_tb import dsb_pkg::*;;
  localparam logic [31:0] E = KEY_ERASED;
  // pin, ukey0, ukey1, tkey0, tkey1, mode, swap
  localparam logic [31:0] KT [9][7] = '{'{1, 1, 2, 0, 0, 0, 0}, '{0, 1, E, 0, E, 2, 0},
    '{0, 1, 2, 0, E, 3, 0}, '{0, 1, 2, 0, 0, 4, 1}, '{0, 3, 2, E, 0, 5, 1},
    '{0, 3, 2, 0, 0, 2, 0}, '{0, 5, 5, E, 0, 5, 1}, '{0, E, 1, 0, 0, 4, 1},
    '{0, E, E, E, E, 1, 0}};
  logic        aclk = 1'b0;
  logic        aresetn, boot_select_pin, serial_wire_boot_pin, fetch_valid;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic        s_axil_rvalid, s_axil_rready, key_rd_req, key_rd_valid;
  logic        fetch_block, fetch_stall, boot_done, swap_active;
  logic [1:0]  s_axil_bresp, s_axil_rresp, flash_busy, rs;
  logic [2:0]  boot_mode;
  logic [3:0]  s_axil_wstrb, lat;
  logic [7:0]  s_axil_awaddr, s_axil_araddr;
  logic [18:0] fetch_offset;
  logic [19:0] key_rd_addr, fetch_addr;
  logic [31:0] s_axil_wdata, s_axil_rdata, key_rd_data, rd, ukey0, ukey1, tkey0, tkey1;
  int          n_fail = 0, num_checks = 0;
  dsb_swap_boot #(.SLOW_OP_CYC(50)) i_dut (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
    .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid,
    .s_axil_arready, .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready,
    .boot_select_pin, .serial_wire_boot_pin, .key_rd_req, .key_rd_addr, .key_rd_valid,
    .key_rd_data, .fetch_valid, .fetch_addr, .fetch_block, .fetch_offset, .fetch_stall,
    .flash_busy, .boot_mode, .boot_done, .swap_active);
  dsb_flash_model i_flash (.aclk, .key_rd_req, .key_rd_addr, .key_rd_valid, .key_rd_data,
    .ukey0, .ukey1, .tkey0, .tkey1, .lat);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // write: both channels offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    @(posedge aclk);
    s_axil_awaddr  <= a;
    s_axil_wdata   <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid  <= 1'b1;
    s_axil_bready  <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      ga = ga | s_axil_awready;
      gw = gw | s_axil_wready;
      if (ga) s_axil_awvalid <= 1'b0;
      if (gw) s_axil_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axil_bvalid !== 1'b1);
    s_axil_bready <= 1'b0;
    chk({30'h0, s_axil_bresp}, {30'h0, e});
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready  <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axil_rvalid !== 1'b1);
    s_axil_rready <= 1'b0;
    rd = s_axil_rdata;
    rs = s_axil_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk(rd, e);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask
  // fetch decode is registered: look two edges after driving the address
  task automatic fet(input logic [19:0] a, input logic st, input logic bk);
    fetch_addr <= a;
    repeat (2) @(posedge aclk);
    chk({11'h0, fetch_stall, fetch_block, fetch_offset}, {11'h0, st, bk, a[18:0]});
  endtask
  task automatic boot(input int i);
    aresetn         <= 1'b0;
    boot_select_pin <= KT[i][0][0];
    {ukey0, ukey1, tkey0, tkey1} <= {KT[i][1], KT[i][2], KT[i][3], KT[i][4]};
    lat             <= i[0] ? 4'h5 : 4'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 300 && boot_done !== 1'b1; k++) @(posedge aclk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test;
  end
  // every reset reruns selection over a new key set
  initial begin
    {aresetn, boot_select_pin, serial_wire_boot_pin, s_axil_awvalid, s_axil_wvalid} = '0;
    {s_axil_bready, s_axil_arvalid, s_axil_rready, flash_busy, lat} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata, fetch_addr} = '0;
    {ukey0, ukey1, tkey0, tkey1} = '0;
    {s_axil_wstrb, fetch_valid} = 5'h1f;
    @(posedge aclk);
    for (int i = 0; i < 9; i++) begin
      boot(i);
      chk({29'h0, boot_mode}, {29'h0, KT[i][5][2:0]});
      chk({31'h0, swap_active}, {31'h0, KT[i][6][0]});
      chk({31'h0, boot_done}, 32'h1);
      rchk(REG_BOOT_STATUS, KT[i][5] | (KT[i][6] << 5) | 32'h10);
      if (i > 0) rchk(REG_UKEY0 + 8'(4 * (i % 4)), KT[i][1 + i % 4]);
      $display("boot case %0d done", i);
    end
    rchk(REG_USER_SETUP, 32'h11);
    axw(REG_USER_SETUP, 32'h19, RESP_OKAY);
    chk({31'h0, swap_active}, 32'h1);
    fet(20'h00010, 1'b0, 1'b1);
    fet(20'h80010, 1'b0, 1'b0);
    axw(REG_USER_SETUP, 32'h11, RESP_OKAY);
    fet(20'h80010, 1'b0, 1'b1);
    fet(20'h7fff0, 1'b0, 1'b0);
    $display("map test done");
    flash_busy <= 2'b01;
    fet(20'h00100, 1'b1, 1'b0);
    fet(20'h80100, 1'b0, 1'b1);
    repeat (60) @(posedge aclk);
    flash_busy <= 2'b00;
    fet(20'h00100, 1'b0, 1'b0);
    rchk(REG_BOOT_STATUS, 32'h51);
    rchk(REG_OP_TIME, 32'h40);
    axw(REG_OP_TIME, 32'h0, RESP_OKAY);
    axw(REG_BOOT_STATUS, 32'h0, RESP_SLVERR);
    rchk(REG_BOOT_STATUS, 32'h11);
    axr(8'h40);
    chk(rd, 32'h0);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("stall and register test done");
    end_of_test;
  end
endmodule // dsb_swap_boot_tb
`default_nettype wire
